/* File: rtl/cpm_pkg.sv */
// Shared constants, field layouts and carrier types for the codec configuration block
package cpm_pkg;
   // Core clock and timing
   localparam longint CLK_HZ = 40_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = int'(CLK_HZ / 1_000_000) * TICK_US;
   localparam int RING_STEP_MS = 2;
   localparam int DEB_STEP_MS = 2;
   localparam int RING_STEP_TICKS = RING_STEP_MS * 1000 / TICK_US;
   localparam int DEB_STEP_TICKS = DEB_STEP_MS * 1000 / TICK_US;

   // Chopper clock synthesis by phase accumulator
   localparam int NCO_W = 24;
   localparam longint CHOP_512_HZ = 512_000;
   localparam longint CHOP_256_HZ = 256_000;
   localparam longint CHOP_MCLK_HZ = 16_384_000;
   localparam logic [NCO_W-1:0] NCO_INC_512 = NCO_W'((CHOP_512_HZ << NCO_W) / CLK_HZ);
   localparam logic [NCO_W-1:0] NCO_INC_256 = NCO_W'((CHOP_256_HZ << NCO_W) / CLK_HZ);
   localparam logic [NCO_W-1:0] NCO_INC_MCLK = NCO_W'((CHOP_MCLK_HZ << NCO_W) / CLK_HZ);

   // Register indices
   localparam logic [2:0] XR_SIG_OUT = 3'h0;
   localparam logic [2:0] XR_SIG_VAL = 3'h1;
   localparam logic [2:0] XR_SIG_DIR = 3'h2;
   localparam logic [2:0] XR_TIMING = 3'h4;
   localparam logic [2:0] XR_GLOBAL = 3'h5;
   localparam logic [2:0] XR_PCM = 3'h6;
   localparam logic [2:0] XR_METER = 3'h7;
   localparam logic [2:0] CR_CTRL_ONE = 3'h1;
   localparam logic [2:0] CR_SLOT = 3'h5;
   localparam int NUM_CR = 7;
   localparam int NUM_CH = 4;

   // Field positions
   localparam int GC_UP_CRASH = 5;
   localparam int GC_DN_CRASH = 4;
   localparam int GC_CHOP_LSB = 2;
   localparam logic [7:0] GC_WR_MASK = 8'h0C;
   localparam int PC_XS = 6;
   localparam int PC_RS = 5;
   localparam int PC_DRV0 = 4;
   localparam int PC_OFS_LSB = 0;
   localparam logic [7:0] PC_WR_MASK = 8'h77;
   localparam int TM_DEB_LSB = 4;
   localparam int TM_RING_LSB = 0;
   localparam int CR1_PU = 0;
   localparam int CR5_LINE = 7;
   localparam int CR5_SLOT_LSB = 0;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Command byte: read, extended, channel, software reset, index
   typedef struct packed {
      logic rd;
      logic ext;
      logic [1:0] chan;
      logic sw_reset;
      logic [2:0] idx;
   } cpm_cmd_t;

   typedef struct packed {
      logic wr;
      logic rd;
      cpm_cmd_t cmd;
      logic [7:0] data;
   } cpm_req_t;
endpackage

/* File: rtl/cpm_ctl_port.sv */
// Serial control port: command byte then one data byte, pins sampled on the core clock
`timescale 1ns/10ps
module cpm_ctl_port
   import cpm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n_pin,
   input wire logic cclk_pin,
   input wire logic cdi_pin,
   input wire logic [7:0] rd_data,
   output logic cdo,
   output logic cdo_oe,
   output cpm_req_t req
);
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] ck_s;
      logic [1:0] di_s;
      logic [7:0] sh;
      logic [2:0] cnt;
      logic byte_no;
      logic load;
      logic [7:0] out_sh;
      logic cdo;
      logic oe;
      cpm_req_t req;
   } cpm_port_st_t;

   cpm_port_st_t s_q, s_d;
   logic ck_rise, ck_fall, sel;
   logic [7:0] byte_in;

   always_comb begin
      s_d = s_q;
      s_d.cs_s = {s_q.cs_s[1:0], cs_n_pin};
      s_d.ck_s = {s_q.ck_s[1:0], cclk_pin};
      s_d.di_s = {s_q.di_s[0], cdi_pin};
      ck_rise = s_q.ck_s[1] & ~s_q.ck_s[2];
      ck_fall = ~s_q.ck_s[1] & s_q.ck_s[2];
      sel = ~s_q.cs_s[1];
      byte_in = {s_q.sh[6:0], s_q.di_s[1]};
      s_d.req.wr = 1'b0;
      s_d.req.rd = 1'b0;
      s_d.load = 1'b0;
      if (s_q.load) begin
         s_d.out_sh = rd_data;
      end
      if (!sel) begin
         s_d.cnt = 3'h0;
         s_d.byte_no = 1'b0;
         s_d.oe = 1'b0;
      end else begin
         if (ck_rise) begin
            s_d.sh = byte_in;
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
               if (!s_q.byte_no) begin
                  s_d.req.cmd = cpm_cmd_t'(byte_in);
                  s_d.byte_no = 1'b1;
                  s_d.req.wr = byte_in[3];
                  s_d.req.rd = byte_in[7] & ~byte_in[3];
                  s_d.load = byte_in[7];
               end else if (!s_q.req.cmd.rd) begin
                  s_d.req.data = byte_in;
                  s_d.req.wr = 1'b1;
               end
            end
         end
         if (ck_fall && s_q.byte_no && s_q.req.cmd.rd) begin
            s_d.cdo = s_q.out_sh[7];
            s_d.out_sh = {s_q.out_sh[6:0], 1'b0};
            s_d.oe = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.cs_s <= 3'h7;
      end else begin
         s_q <= s_d;
      end
   end

   assign cdo = s_q.cdo;
   assign cdo_oe = s_q.oe;
   assign req = s_q.req;
endmodule

/* File: rtl/cpm_tone_clk.sv */
// Millisecond tick, ring generator waveform and chopper clock synthesis
`timescale 1ns/10ps
module cpm_tone_clk
   import cpm_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] ring_code,
   input wire logic [1:0] chop_sel,
   input wire logic chop_en,
   output logic ms_tick,
   output logic ring_pin,
   output logic chop_pin
);
   typedef struct packed {
      logic [16:0] div;
      logic tick;
      logic [4:0] half;
      logic ring;
      logic [NCO_W-1:0] acc;
      logic chop;
   } cpm_tone_st_t;

   cpm_tone_st_t s_q, s_d;
   logic [NCO_W-1:0] inc;
   logic [4:0] half_len;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.div >= 17'(TICK_CNT - 1)) begin
         s_d.div = 17'h0_0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 17'h0_0001;
      end
      // Full period is code steps, so each half lasts code steps over two
      half_len = 5'(ring_code * RING_STEP_TICKS / 2);
      if (ring_code == 4'h0) begin
         s_d.ring = 1'b1; // RQ1
         s_d.half = 5'h00;
      end else if (ring_code == 4'hF) begin
         s_d.ring = 1'b0; // RQ1
         s_d.half = 5'h00;
      end else if (s_q.tick) begin
         if (s_q.half + 5'h01 >= half_len) begin
            s_d.ring = ~s_q.ring; // RQ2
            s_d.half = 5'h00;
         end else begin
            s_d.half = s_q.half + 5'h01;
         end
      end
      case (chop_sel)
         2'h1: inc = NCO_INC_512;
         2'h2: inc = NCO_INC_256;
         2'h3: inc = NCO_INC_MCLK;
         default: inc = '0;
      endcase
      // Fractional synthesis: average rate slightly below target from the truncated increment, edges jitter by one core cycle
      if (chop_sel == 2'h0 || !chop_en) begin
         s_d.acc = '0;
         s_d.chop = 1'b1; // RQ5
      end else begin
         s_d.acc = s_q.acc + inc;
         s_d.chop = s_q.acc[NCO_W-1]; // RQ5
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.ring <= 1'b1;
         s_q.chop <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign ms_tick = s_q.tick;
   assign ring_pin = s_q.ring;
   assign chop_pin = s_q.chop;
endmodule

/* File: rtl/cpm_codec_cfg.sv */
// Codec global configuration, operating modes and PCM highway timing
// Contract
// RQ1: Ring code zero high, all ones low
// RQ2: Codes 1..14 give ring period 2ms steps
// RQ3: Two read-only crash flags, one per line
// RQ4: Slot collision sets flag, disables colliders
// RQ5: Chopper select: high, 512k, 256k, master
// RQ6: Chopper needs powered channel and data clock
// RQ7: Read-only two-bit revision field
// RQ8: Transmit slope selects launch edge
// RQ9: Receive slope selects sampling edge
// RQ10: Last bit driven whole or half period
// RQ11: Offset delays slots zero to seven clocks
// RQ12: Eight-bit meter offset register
// RQ13: Any reset clears all configuration registers
// RQ14: Basic setting disables functions, pins inputs
// RQ15: Basic setting floats PCM, grounds outputs
// RQ16: Reset release enters standby automatically
// RQ17: Power-up bit zero means channel standby
// RQ18: Standby floats lines, control port works
// RQ19: Power-up bit one activates channel
// RQ20: Controller resets if inputs preceded supply
// RQ21: Signal change latched after stable debounce
// RQ22: Fixed-zero bits read zero, ignore writes
`timescale 1ns/10ps
module cpm_codec_cfg
   import cpm_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES,
   parameter logic [1:0] REVISION = 2'h2 // Arbitrary value
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic CCLK,
   input wire logic CDI,
   output logic CDO,
   output logic CDO_OE,
   input wire logic PCM_BIT_CLOCK,
   input wire logic PCM_FRAME_SYNC,
   input wire logic UPSTREAM_LINE_I,
   output logic UPSTREAM_LINE_O,
   output logic UPSTREAM_LINE_OE,
   input wire logic DOWNSTREAM_LINE_I,
   output logic DOWNSTREAM_LINE_O,
   output logic DOWNSTREAM_LINE_OE,
   input wire logic [31:0] VOICE_TX,
   output logic [31:0] VOICE_RX,
   input wire logic [3:0] BIDIR_SIGNAL_PIN_I,
   output logic [3:0] BIDIR_SIGNAL_PIN_O,
   output logic [3:0] BIDIR_SIGNAL_PIN_OE,
   output logic [3:0] SIGNAL_OUT_PIN,
   output logic SIG_CHANGE,
   output logic [3:0] ANALOG_MUTE,
   output logic [7:0] METER_OFFSET,
   output logic RING_GEN_PIN,
   output logic CHOPPER_PIN
);
   typedef struct packed {
      logic [NUM_CH-1:0][NUM_CR-1:0][7:0] cr;
      logic [7:0][7:0] xr;
      logic [1:0][3:0] sig_s;
      logic [3:0] sig_prev;
      logic [3:0] sig_lat;
      logic [4:0] deb_cnt;
      logic sig_chg;
      logic [2:0] bcl_s;
      logic [2:0] fs_s;
      logic fs_pend;
      logic [8:0] bit_cnt;
      logic [1:0] ln_o;
      logic [1:0] ln_oe;
      logic [1:0][1:0] ln_s;
      logic [NUM_CH-1:0][7:0] rx_sh;
      logic [NUM_CH-1:0][7:0] voice_rx;
      logic dcl_seen;
   } cpm_top_st_t;

   cpm_top_st_t s_q, s_d;
   cpm_req_t req;
   logic [7:0] rd_data;
   logic ms_tick;
   logic [NUM_CH-1:0] pu, tx_line, conflict;
   logic [NUM_CH-1:0][4:0] slot;
   logic [1:0] crash;
   logic xs, rs, drv0;
   logic [2:0] pcm_ofs;
   logic bcl_rise, bcl_fall, launch, sample;
   logic [8:0] cnt_nxt, pos;
   logic pos_ok;
   logic [3:0] deb_code, sig_in;
   logic [4:0] deb_lim;
   logic [1:0] own_any;
   logic [1:0] own_bit;

   cpm_ctl_port u_port (
      .clk(CLK),
      .rst(RST),
      .cs_n_pin(CS_N),
      .cclk_pin(CCLK),
      .cdi_pin(CDI),
      .rd_data(rd_data),
      .cdo(CDO),
      .cdo_oe(CDO_OE),
      .req(req)
   );

   cpm_tone_clk #(
      .TICK_CNT(TICK_CNT)
   ) u_tone (
      .clk(CLK),
      .rst(RST),
      .ring_code(s_q.xr[XR_TIMING][TM_RING_LSB +: 4]),
      .chop_sel(s_q.xr[XR_GLOBAL][GC_CHOP_LSB +: 2]),
      .chop_en((|pu) & s_q.dcl_seen), // RQ6
      .ms_tick(ms_tick),
      .ring_pin(RING_GEN_PIN),
      .chop_pin(CHOPPER_PIN)
   );

   // Slot map and collision detection
   always_comb begin
      conflict = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         pu[c] = s_q.cr[c][CR_CTRL_ONE][CR1_PU]; // RQ17 RQ19
         tx_line[c] = s_q.cr[c][CR_SLOT][CR5_LINE];
         slot[c] = s_q.cr[c][CR_SLOT][CR5_SLOT_LSB +: 5];
      end
      for (int a = 0; a < NUM_CH; a++) begin
         for (int b = 0; b < NUM_CH; b++) begin
            if (a != b && pu[a] && pu[b] && tx_line[a] == tx_line[b] && slot[a] == slot[b]) begin
               conflict[a] = 1'b1; // RQ4
            end
         end
      end
      crash = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (conflict[c]) begin
            crash[tx_line[c]] = 1'b1; // RQ3 RQ4
         end
      end
   end

   assign xs = s_q.xr[XR_PCM][PC_XS];
   assign rs = s_q.xr[XR_PCM][PC_RS];
   assign drv0 = s_q.xr[XR_PCM][PC_DRV0];
   assign pcm_ofs = s_q.xr[XR_PCM][PC_OFS_LSB +: 3];
   assign deb_code = s_q.xr[XR_TIMING][TM_DEB_LSB +: 4];
   assign deb_lim = 5'(deb_code * DEB_STEP_TICKS);
   assign sig_in = s_q.sig_s[1];

   // Register read view
   always_comb begin
      rd_data = 8'h00;
      if (req.cmd.ext) begin
         case (req.cmd.idx)
            XR_SIG_VAL: begin
               for (int i = 0; i < 4; i++) begin
                  rd_data[i] = s_q.xr[XR_SIG_DIR][i] ? s_q.xr[XR_SIG_VAL][i] : s_q.sig_lat[i]; // RQ18
               end
            end
            XR_GLOBAL: begin
               rd_data[GC_UP_CRASH] = crash[0]; // RQ3
               rd_data[GC_DN_CRASH] = crash[1]; // RQ3
               rd_data[GC_CHOP_LSB +: 2] = s_q.xr[XR_GLOBAL][GC_CHOP_LSB +: 2];
               rd_data[1:0] = REVISION; // RQ7
            end
            default: rd_data = s_q.xr[req.cmd.idx];
         endcase
      end else if (int'(req.cmd.idx) < NUM_CR) begin
         rd_data = s_q.cr[req.cmd.chan][req.cmd.idx];
      end
   end

   always_comb begin
      s_d = s_q;
      // Register writes and software reset
      if (req.wr) begin
         if (req.cmd.sw_reset) begin
            s_d.cr = '0; // RQ13
            s_d.xr = '0; // RQ13 RQ14
            s_d.sig_chg = 1'b0;
         end else if (req.cmd.ext) begin
            case (req.cmd.idx)
               XR_GLOBAL: s_d.xr[XR_GLOBAL] = req.data & GC_WR_MASK; // RQ22
               XR_PCM: s_d.xr[XR_PCM] = req.data & PC_WR_MASK; // RQ22
               default: s_d.xr[req.cmd.idx] = req.data; // RQ12
            endcase
         end else if (int'(req.cmd.idx) < NUM_CR) begin
            s_d.cr[req.cmd.chan][req.cmd.idx] = req.data;
         end
      end

      // Signalling inputs: only the second stage is looked at
      s_d.sig_s = {s_q.sig_s[0], BIDIR_SIGNAL_PIN_I};
      s_d.sig_prev = sig_in;
      if (req.rd && req.cmd.ext && req.cmd.idx == XR_SIG_VAL) begin
         s_d.sig_chg = 1'b0;
      end
      if (deb_code == 4'h0) begin
         s_d.sig_lat = sig_in; // RQ21
         s_d.deb_cnt = 5'h00;
      end else if (sig_in != s_q.sig_prev) begin
         s_d.deb_cnt = 5'h00;
      end else if (sig_in != s_q.sig_lat) begin
         if (s_q.deb_cnt >= deb_lim) begin
            s_d.sig_lat = sig_in; // RQ21
            s_d.sig_chg = 1'b1; // RQ21
            s_d.deb_cnt = 5'h00;
         end else if (ms_tick) begin
            s_d.deb_cnt = s_q.deb_cnt + 5'h01;
         end
      end

      // PCM clock edges and frame position
      s_d.bcl_s = {s_q.bcl_s[1:0], PCM_BIT_CLOCK};
      s_d.fs_s = {s_q.fs_s[1:0], PCM_FRAME_SYNC};
      s_d.ln_s = {s_q.ln_s[0], {DOWNSTREAM_LINE_I, UPSTREAM_LINE_I}};
      bcl_rise = s_q.bcl_s[1] & ~s_q.bcl_s[2];
      bcl_fall = ~s_q.bcl_s[1] & s_q.bcl_s[2];
      if (bcl_rise) begin
         s_d.dcl_seen = 1'b1;
      end
      launch = xs ? bcl_fall : bcl_rise; // RQ8
      sample = rs ? bcl_rise : bcl_fall; // RQ9
      if (s_q.fs_s[1] && !s_q.fs_s[2]) begin
         s_d.fs_pend = 1'b1;
      end
      cnt_nxt = s_q.fs_pend ? 9'h000 : s_q.bit_cnt + 9'h001;
      if (launch) begin
         s_d.bit_cnt = cnt_nxt;
         s_d.fs_pend = 1'b0;
      end
      pos = (launch ? cnt_nxt : s_q.bit_cnt) - 9'(pcm_ofs); // RQ11
      pos_ok = (launch ? cnt_nxt : s_q.bit_cnt) >= 9'(pcm_ofs) && !pos[8];

      // Transmit: a colliding channel never owns its slot
      own_any = '0;
      own_bit = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         if (pu[c] && !conflict[c] && pos_ok && slot[c] == pos[7:3]) begin // RQ4 RQ11
            own_any[tx_line[c]] = 1'b1;
            own_bit[tx_line[c]] = VOICE_TX[c*8 + 7 - int'(pos[2:0])];
         end
      end
      for (int l = 0; l < 2; l++) begin
         if (launch) begin
            s_d.ln_oe[l] = own_any[l]; // RQ8 RQ17 RQ18
            s_d.ln_o[l] = own_bit[l];
         end else if ((xs ? bcl_rise : bcl_fall) && drv0 && pos[2:0] == 3'h7) begin
            s_d.ln_oe[l] = 1'b0; // RQ10
         end
      end

      // Receive on the opposite line in the same slot
      for (int c = 0; c < NUM_CH; c++) begin
         if (sample && pu[c] && pos_ok && slot[c] == pos[7:3]) begin // RQ9 RQ18
            s_d.rx_sh[c] = {s_q.rx_sh[c][6:0], s_q.ln_s[1][~tx_line[c]]};
            if (pos[2:0] == 3'h7) begin
               s_d.voice_rx[c] = {s_q.rx_sh[c][6:0], s_q.ln_s[1][~tx_line[c]]};
            end
         end
      end

      // Software reset clears registers and line enables; unlike the pin it keeps dcl_seen, bit_cnt and sig_lat
      if (req.wr && req.cmd.sw_reset) begin
         s_d.ln_oe = 2'b00; // RQ15
         s_d.rx_sh = '0;
         s_d.voice_rx = '0;
      end
   end

   // Reset release drops straight into standby: every power-up bit is zero
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_q <= '0; // RQ13 RQ14 RQ15 RQ16
      end else begin
         s_q <= s_d;
      end
   end

   assign UPSTREAM_LINE_O = s_q.ln_o[0];
   assign UPSTREAM_LINE_OE = s_q.ln_oe[0]; // RQ15 RQ18
   assign DOWNSTREAM_LINE_O = s_q.ln_o[1];
   assign DOWNSTREAM_LINE_OE = s_q.ln_oe[1]; // RQ15 RQ18
   assign VOICE_RX = s_q.voice_rx;
   assign BIDIR_SIGNAL_PIN_O = s_q.xr[XR_SIG_VAL][3:0];
   assign BIDIR_SIGNAL_PIN_OE = s_q.xr[XR_SIG_DIR][3:0]; // RQ14
   assign SIGNAL_OUT_PIN = s_q.xr[XR_SIG_OUT][3:0]; // RQ15
   assign SIG_CHANGE = s_q.sig_chg;
   assign ANALOG_MUTE = ~pu; // RQ15 RQ18
   assign METER_OFFSET = s_q.xr[XR_METER]; // RQ12
endmodule

/* File: dv/cpm_codec_cfg_monitor.sv */
// Port assertions for the codec configuration block
`timescale 1ns/10ps
module cpm_codec_cfg_monitor
   import cpm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic CDO_OE,
   input wire logic UPSTREAM_LINE_OE,
   input wire logic DOWNSTREAM_LINE_OE,
   input wire logic [3:0] BIDIR_SIGNAL_PIN_OE,
   input wire logic [3:0] SIGNAL_OUT_PIN,
   input wire logic SIG_CHANGE,
   input wire logic [3:0] ANALOG_MUTE,
   input wire logic [7:0] METER_OFFSET,
   input wire logic RING_GEN_PIN,
   input wire logic CHOPPER_PIN
);
   logic idle;
   assign idle = (ANALOG_MUTE == 4'hF);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_rst_floats: assert property ($fell(RST) |-> !UPSTREAM_LINE_OE && !DOWNSTREAM_LINE_OE && !CDO_OE)
      else $error("line driven after reset");
   a_rst_pins: assert property ($fell(RST) |-> BIDIR_SIGNAL_PIN_OE == 4'h0 && SIGNAL_OUT_PIN == 4'h0)
      else $error("signal pins not idle after reset");
   a_rst_regs: assert property ($fell(RST) |-> METER_OFFSET == 8'h00 && !SIG_CHANGE)
      else $error("register not cleared by reset");
   a_rst_standby: assert property ($fell(RST) |-> idle [*2])
      else $error("channel active after reset");
   a_rst_ring: assert property ($fell(RST) |-> RING_GEN_PIN && CHOPPER_PIN)
      else $error("ring or chopper pin low after reset");
   a_idle_float: assert property (idle [*3] |-> !UPSTREAM_LINE_OE && !DOWNSTREAM_LINE_OE)
      else $error("line driven in standby");
   a_idle_chop: assert property (idle [*3] |-> $stable(CHOPPER_PIN))
      else $error("chopper runs with no channel up");
   a_port_quiet: assert property (CS_N [*6] |-> !CDO_OE)
      else $error("serial out driven while deselected");
   c_up_drive: cover property ($rose(UPSTREAM_LINE_OE));
   c_read_out: cover property ($rose(CDO_OE));
   c_ring_fall: cover property ($fell(RING_GEN_PIN));
endmodule
bind cpm_codec_cfg cpm_codec_cfg_monitor u_cpm_codec_cfg_monitor (.CLK(CLK), .RST(RST), .CS_N(CS_N),
   .CDO_OE(CDO_OE), .UPSTREAM_LINE_OE(UPSTREAM_LINE_OE), .DOWNSTREAM_LINE_OE(DOWNSTREAM_LINE_OE),
   .BIDIR_SIGNAL_PIN_OE(BIDIR_SIGNAL_PIN_OE), .SIGNAL_OUT_PIN(SIGNAL_OUT_PIN), .SIG_CHANGE(SIG_CHANGE),
   .ANALOG_MUTE(ANALOG_MUTE), .METER_OFFSET(METER_OFFSET), .RING_GEN_PIN(RING_GEN_PIN),
   .CHOPPER_PIN(CHOPPER_PIN));

/* File: dv/cpm_pcm_host.sv */
// PCM highway master: bit clock in frames only, far-side data, line capture
`timescale 1ns/10ps
module cpm_pcm_host
   import cpm_pkg::*;
(
   input wire logic up_o,
   input wire logic up_oe,
   input wire logic dn_o,
   input wire logic dn_oe,
   output logic bclk,
   output logic fs,
   output logic up_w,
   output logic dn_w,
   output logic [23:0] cap_r,
   output logic [23:0] cap_f,
   output logic up_seen
);
   logic [7:0] pat;
   logic tog;
   logic dnd;
   // No pull on the lines: a released line toggles so stale data never matches
   assign up_w = up_oe ? up_o : tog;
   assign dn_w = dn_oe ? dn_o : dnd;
   initial begin
      pat = 8'h3C;
      tog = 1'b0;
      dnd = 1'b0;
      bclk = 1'b0;
      fs = 1'b0;
      up_seen = 1'b0;
   end
   always @(posedge up_oe) up_seen = 1'b1;
   task automatic frame();
      up_seen = 1'b0;
      fs = 1'b1;
      #100;
      for (int k = 0; k < 24; k++) begin
         bclk = 1'b1;
         dnd = (k < 8) ? pat[7-k] : ~dnd;
         tog = ~tog;
         #50 cap_r = {cap_r[22:0], up_w};
         #50 bclk = 1'b0;
         fs = 1'b0;
         #50 cap_f = {cap_f[22:0], up_w};
         #50;
      end
   endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the codec configuration block
`timescale 1ns/10ps
module testbench;
   import cpm_pkg::*;
   localparam int TK = 40;
   localparam logic [1:0] REV = 2'h2; // Arbitrary value
   logic clk, rst, cs_n, cclk, cdi, cdo, cdo_oe, bclk, fs, up_w, up_o, up_oe, dn_w, dn_o, dn_oe;
   logic ring, chop, sig_chg, up_seen, p;
   logic [31:0] voice_tx, voice_rx;
   logic [3:0] sb_i, sb_o, sb_oe, so, mute;
   logic [7:0] meter, rd;
   logic [23:0] cap_r, cap_f;
   int n_errors, n_tests, n, e;
   int ofs[3] = '{0, 3, 7};
   int codes[2] = '{1, 14};
   longint fr[4] = '{0, CHOP_512_HZ, CHOP_256_HZ, CHOP_MCLK_HZ};
   cpm_codec_cfg #(.TICK_CNT(TK), .REVISION(REV)) u_cpm_codec_cfg (.CLK(clk), .RST(rst), .CS_N(cs_n),
      .CCLK(cclk), .CDI(cdi), .CDO(cdo), .CDO_OE(cdo_oe), .PCM_BIT_CLOCK(bclk), .PCM_FRAME_SYNC(fs),
      .UPSTREAM_LINE_I(up_w), .UPSTREAM_LINE_O(up_o), .UPSTREAM_LINE_OE(up_oe),
      .DOWNSTREAM_LINE_I(dn_w), .DOWNSTREAM_LINE_O(dn_o), .DOWNSTREAM_LINE_OE(dn_oe),
      .VOICE_TX(voice_tx), .VOICE_RX(voice_rx), .BIDIR_SIGNAL_PIN_I(sb_i), .BIDIR_SIGNAL_PIN_O(sb_o),
      .BIDIR_SIGNAL_PIN_OE(sb_oe), .SIGNAL_OUT_PIN(so), .SIG_CHANGE(sig_chg), .ANALOG_MUTE(mute),
      .METER_OFFSET(meter), .RING_GEN_PIN(ring), .CHOPPER_PIN(chop));
   cpm_pcm_host u_cpm_pcm_host (.up_o(up_o), .up_oe(up_oe), .dn_o(dn_o), .dn_oe(dn_oe), .bclk(bclk),
      .fs(fs), .up_w(up_w), .dn_w(dn_w), .cap_r(cap_r), .cap_f(cap_f), .up_seen(up_seen));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Command byte then data byte; half periods of 5 cycles keep above the 4-cycle minimum
   task automatic xfer(input logic [7:0] c, input logic [7:0] d);
      logic [15:0] s;
      s = {c, d};
      cs_n = 1'b0;
      repeat (3) @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         cdi = s[i];
         repeat (5) @(negedge clk);
         if (i < 8) rd[i] = cdo;
         cclk = 1'b1;
         repeat (5) @(negedge clk);
         cclk = 1'b0;
      end
      repeat (3) @(negedge clk);
      cs_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask
   task automatic wr(input logic x, input logic [1:0] ch, input logic [2:0] idx, input logic [7:0] d);
      xfer({1'b0, x, ch, 1'b0, idx}, d);
   endtask
   task automatic rc(input logic x, input logic [1:0] ch, input logic [2:0] idx, input logic [7:0] exp);
      xfer({1'b1, x, ch, 1'b0, idx}, 8'h00);
      chk(rd, exp);
   endtask
   task automatic span();
      logic v;
      v = ring;
      n = 0;
      while (ring === v && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   initial begin
      rst = 1'b1;
      cs_n = 1'b1;
      cclk = 1'b0;
      cdi = 1'b0;
      voice_tx = 32'h0000_00C5;
      sb_i = 4'h0;
      n_errors = 0;
      n_tests = 0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk({so, sb_oe, mute, meter, ring, chop}, {4'h0, 4'h0, 4'hF, 8'h00, 2'b11});
      rc(1, 0, XR_GLOBAL, {6'h00, REV});
      rc(1, 0, XR_PCM, 8'h00);
      rc(1, 0, XR_METER, 8'h00);
      rc(0, 0, 3'h7, 8'h00);
      $display("reset values done");
      wr(1, 0, XR_GLOBAL, 8'hFF);
      rc(1, 0, XR_GLOBAL, {6'h03, REV});
      wr(1, 0, XR_PCM, 8'hFF);
      rc(1, 0, XR_PCM, 8'h77);
      wr(1, 0, XR_METER, 8'hA5);
      rc(1, 0, XR_METER, 8'hA5);
      chk(meter, 8'hA5);
      wr(1, 0, XR_GLOBAL, 8'h00);
      wr(1, 0, XR_PCM, 8'h00);
      $display("register access done");
      wr(1, 0, XR_TIMING, 8'h0F);
      chk(ring, 1'b0);
      for (int i = 0; i < 2; i++) begin
         wr(1, 0, XR_TIMING, 8'(codes[i]));
         span();
         span();
         chk(n, codes[i] * TK);
      end
      wr(1, 0, XR_TIMING, 8'h00);
      chk(ring, 1'b1);
      $display("ring generator done");
      wr(1, 0, XR_SIG_OUT, 8'h05);
      wr(1, 0, XR_SIG_DIR, 8'h0F);
      wr(1, 0, XR_SIG_VAL, 8'h0A);
      chk({so, sb_oe, sb_o}, 12'h5FA);
      wr(1, 0, XR_SIG_DIR, 8'h00);
      wr(1, 0, XR_TIMING, 8'h10);
      sb_i = 4'h6;
      repeat (40) @(negedge clk);
      chk(sig_chg, 1'b0);
      repeat (100) @(negedge clk);
      chk(sig_chg, 1'b1);
      rc(1, 0, XR_SIG_VAL, 8'h06);
      chk(sig_chg, 1'b0);
      $display("signal pins done");
      wr(0, 0, CR_CTRL_ONE, 8'h01);
      chk(mute, 4'hE);
      for (int i = 0; i < 3; i++) begin
         wr(1, 0, XR_PCM, 8'(ofs[i]));
         u_cpm_pcm_host.frame();
         chk(cap_f[23-ofs[i] -: 8], 8'hC5);
         // Far side sends its byte in the first eight bits, so only the zero-offset frame lands in slot 0
         if (i == 0) chk(voice_rx[7:0], 8'h3C);
      end
      wr(1, 0, XR_PCM, 8'h40);
      u_cpm_pcm_host.frame();
      chk(cap_r[22 -: 8], 8'hC5);
      // Half-period last bit: released line shows the host's toggle at the next rise
      voice_tx = 32'h0000_00C4;
      wr(1, 0, XR_PCM, 8'h10);
      u_cpm_pcm_host.frame();
      chk({cap_f[23 -: 8], cap_r[15]}, 9'h189);
      $display("pcm transfer done");
      for (int s = 0; s < 4; s++) begin
         wr(1, 0, XR_GLOBAL, 8'(s << GC_CHOP_LSB));
         e = int'(fr[s] / 10000);
         n = 0;
         p = chop;
         repeat (4000) begin
            @(negedge clk);
            if (chop && !p) n++;
            p = chop;
         end
         chk(n >= e && n <= e + 1, 1'b1);
      end
      wr(1, 0, XR_GLOBAL, 8'h00);
      chk(chop, 1'b1);
      $display("chopper done");
      wr(0, 1, CR_CTRL_ONE, 8'h01);
      rc(1, 0, XR_GLOBAL, {6'h08, REV});
      u_cpm_pcm_host.frame();
      chk(up_seen, 1'b0);
      wr(0, 1, CR_SLOT, 8'h05);
      rc(1, 0, XR_GLOBAL, {6'h00, REV});
      wr(0, 0, CR_CTRL_ONE, 8'h00);
      wr(0, 1, CR_CTRL_ONE, 8'h00);
      u_cpm_pcm_host.frame();
      chk({up_seen, mute}, 5'h0F);
      $display("collision and standby done");
      wr(1, 0, XR_METER, 8'h5A);
      xfer(8'h48, 8'hFF);
      rc(1, 0, XR_METER, 8'h00);
      chk({meter, so}, 12'h000);
      wr(1, 0, XR_PCM, 8'h33);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      rc(1, 0, XR_PCM, 8'h00);
      $display("resets done");
      tally_and_finish();
   end
endmodule
